// file: dv/phy_link_model.sv
// Purpose: Behavioural PHY that answers serial register requests
// Assumes: Frames are start, type, address, write data on writes only, stop
// Notes: Read replies wait dly_i cycles; idle status fields keep toggling
`timescale 1ns/100ps
module phy_link_model (
  input wire logic mclk_i,
  input wire logic lreq_i,
  input wire node_phy_pkg::phy_status_t ev_i,
  input wire logic [3:0] dly_i,
  output node_phy_pkg::phy_status_t status_o
);
  node_phy_pkg::phy_status_t rsp;
  logic [7:0] regs [16];
  logic [14:0] sh;
  logic [2:0] ty;
  // Bench events win; the bench never overlaps them with a reply
  assign status_o = ev_i.valid ? ev_i : rsp;
  initial begin
    for (int i = 0; i < 16; i++) begin
      regs[i] = 8'h5A ^ 8'(i * 17);
    end
    rsp = '0;
    forever begin
      @(posedge mclk_i);
      // Stale fields must not look like the last reply
      rsp <= {1'b0, ~rsp[$bits(rsp)-2:0]};
      if (lreq_i === 1'b1) begin
        repeat (7) begin
          @(posedge mclk_i);
          sh = {sh[13:0], lreq_i};
        end
        ty = sh[6:4];
        if (ty == node_phy_pkg::LREQ_WR) begin
          repeat (8) begin
            @(posedge mclk_i);
            sh = {sh[13:0], lreq_i};
          end
          regs[sh[11:8]] = sh[7:0];
        end
        @(posedge mclk_i);
        if (ty == node_phy_pkg::LREQ_RD) begin
          repeat (dly_i) @(posedge mclk_i);
          rsp <= '{valid: 1'b1, reg_xfer: 1'b1, reg_addr: sh[3:0],
                   reg_data: regs[sh[3:0]], default: '0};
        end
      end
    end
  end
endmodule

// file: dv/test_node_id_and_phy_reg_access.sv
// Purpose: Self-checking bench for node identity and PHY register access
// Assumes: One APB wait state; PHY modelled behaviourally
// Notes: Random values from a fixed xorshift seed
`timescale 1ns/100ps
module test_node_id_and_phy_reg_access;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, lreq, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] nid;
  logic [3:0] dly;
  logic [31:0] seed = 32'h0000_4A0A;
  logic [7:0] mirror [16];
  int err_count = 0;
  int num_checks = 0;
  node_phy_pkg::phy_status_t ev, st;

  node_phy_regs uut (.mclk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .phy_status_i(st), .lreq_o(lreq),
    .node_id_o(nid), .irq_o(irq));
  phy_link_model phy (.mclk_i(clk), .lreq_i(lreq), .ev_i(ev), .dly_i(dly), .status_o(st));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic phy_ev(input logic br, input logic sid, input logic [5:0] nn,
                        input logic rt, input logic cable_power_good);
    @(posedge clk);
    ev <= '{valid: 1'b1, bus_reset: br, self_id_done: sid, node_number: nn, root: rt,
            cable_power: cable_power_good, default: '0};
    @(posedge clk);
    ev <= '0;
  endtask

  task automatic wait_bit(input int b, input logic v);
    for (int k = 0; k < 30; k++) begin
      apb(1'b0, node_phy_pkg::PHY_ACC_OFS, 32'h0);
      if (rd[b] === v) break;
    end
    chk("poll bit", {31'h0, v}, {31'h0, rd[b]});
  endtask

  task results;
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results;
  end

  initial begin
    logic [9:0] bn;
    logic [5:0] nn;
    logic [3:0] a;
    logic [7:0] d;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    dly = '0;
    ev = '0;
    for (int i = 0; i < 16; i++) mirror[i] = 8'h5A ^ 8'(i * 17);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, node_phy_pkg::NODE_ID_OFS, 32'h0);
    chk("node id reset", 32'h0000_FFC0, rd);
    chk("mapped no error", 32'h0, {31'h0, err});
    chk("node id out", 32'h0000_FFC0, {16'h0, nid});
    apb(1'b0, node_phy_pkg::PHY_ACC_OFS, 32'h0);
    chk("phy access reset", 32'h0, rd);
    apb(1'b0, 12'h0F4, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    for (int t = 0; t < 4; t++) begin
      bn = 10'(rnd());
      nn = (t == 0) ? 6'h3F : 6'(rnd());
      // Software tries to set every flag and the node number too
      apb(1'b1, node_phy_pkg::NODE_ID_OFS, {16'hFFFF, bn, 6'h3F});
      phy_ev(1'b1, 1'b0, 6'h00, t[0], t[1]);
      apb(1'b0, node_phy_pkg::NODE_ID_OFS, 32'h0);
      chk("after bus reset", {1'b0, t[0], 2'b0, t[1], 11'h0, bn, 6'h0},
          rd & 32'hFFFF_FFC0);
      phy_ev(1'b0, 1'b1, nn, 1'b0, t[1]);
      apb(1'b0, node_phy_pkg::NODE_ID_OFS, 32'h0);
      chk("after self id", {1'b1, t[0], 2'b0, t[1], 11'h0, bn, nn}, rd);
      chk("node id out", {16'h0, bn, nn}, {16'h0, nid});
    end
    apb(1'b0, node_phy_pkg::IRQ_STS_OFS, 32'h0);
    chk("irq status", 32'h3, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, node_phy_pkg::IRQ_MSK_OFS, 32'h1);
    apb(1'b0, node_phy_pkg::IRQ_MSK_OFS, 32'h0);
    chk("irq mask", 32'h1, rd);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, node_phy_pkg::IRQ_STS_OFS, 32'h1);
    apb(1'b0, node_phy_pkg::IRQ_STS_OFS, 32'h0);
    chk("irq cleared", 32'h2, rd);
    chk("irq low", 32'h0, {31'h0, irq});
    apb(1'b1, node_phy_pkg::IRQ_STS_OFS, 32'h7);
    apb(1'b1, node_phy_pkg::IRQ_MSK_OFS, 32'h4);
    for (int t = 0; t < 10; t++) begin
      d = 8'(rnd());
      dly <= 4'(rnd());
      if (!t[0]) begin
        a = 4'(rnd());
        apb(1'b1, node_phy_pkg::PHY_ACC_OFS, {16'h7000, 4'h7, a, d});
        apb(1'b0, node_phy_pkg::PHY_ACC_OFS, 32'h0);
        chk("reserved zero", 32'h0, rd & 32'h7000_3000);
        chk("write request", {16'h0, 2'b01, 2'b00, a, d}, rd & 32'h0000_FFFF);
        wait_bit(14, 1'b0);
        mirror[a] = d;
      end else begin
        apb(1'b1, node_phy_pkg::PHY_ACC_OFS, {16'h0, 4'h8, a, d});
        apb(1'b0, node_phy_pkg::PHY_ACC_OFS, 32'h0);
        chk("done cleared", {1'b0, 15'h0, 4'h8, a, d}, rd & 32'h8000_FFFF);
        wait_bit(31, 1'b1);
        chk("read request clear", 32'h0, {31'h0, rd[15]});
        chk("returned reg", {20'h0, a, mirror[a]}, {20'h0, rd[27:16]});
        chk("irq transfer", 32'h1, {31'h0, irq});
        apb(1'b1, node_phy_pkg::IRQ_STS_OFS, 32'h4);
      end
    end
    results;
  end
endmodule

// file: include/node_phy_pkg.sv
// Purpose: Shared constants and carriers for node identity and PHY access
// Assumes: 32-bit APB register bus, byte addresses
// Notes: Interrupt status and mask offsets sit after the PHY access word
package node_phy_pkg;

  localparam logic [11:0] NODE_ID_OFS = 12'h0E8;
  localparam logic [11:0] PHY_ACC_OFS = 12'h0EC;
  localparam logic [11:0] IRQ_STS_OFS = 12'h0F8;
  localparam logic [11:0] IRQ_MSK_OFS = 12'h0FC;

  // Node identity word
  localparam int VALID_BIT = 31;
  localparam int ROOT_BIT = 30;
  localparam int CPS_BIT = 27;
  localparam int BUSNUM_LSB = 6;
  localparam int BUSNUM_W = 10;
  localparam int NODENUM_W = 6;
  localparam logic [9:0] BUSNUM_RST = 10'h3FF;
  localparam logic [5:0] NODENUM_RST = 6'h00;

  // PHY access word
  localparam int DONE_BIT = 31;
  localparam int RADDR_LSB = 24;
  localparam int RDATA_LSB = 16;
  localparam int RDREQ_BIT = 15;
  localparam int WRREQ_BIT = 14;
  localparam int TADDR_LSB = 8;
  localparam int WDATA_LSB = 0;
  localparam logic [31:0] PHY_ACC_RST = 32'h0000_0000;

  // Interrupt events
  localparam int EV_BUS_RESET = 0;
  localparam int EV_SELF_ID = 1;
  localparam int EV_REG_XFER = 2;
  localparam int EV_W = 3;

  // Link request framing: start bit, type, address, data on writes only, stop bit
  localparam logic [2:0] LREQ_RD = 3'h4;
  localparam logic [2:0] LREQ_WR = 3'h5;
  localparam logic [4:0] LREQ_RD_LEN = 5'h09;
  localparam logic [4:0] LREQ_WR_LEN = 5'h11;
  localparam int LREQ_SH_W = 17;

  typedef struct packed {
    logic valid;
    logic bus_reset;
    logic self_id_done;
    logic [5:0] node_number;
    logic root;
    logic cable_power;
    logic reg_xfer;
    logic [3:0] reg_addr;
    logic [7:0] reg_data;
  } phy_status_t;

  typedef enum {REQ_IDLE, REQ_SEND} req_state_t;

endpackage

// file: verilog/lreq_serializer.sv
// Purpose: Shifts one PHY register request out on the link request pin
// Assumes: Start is only taken while idle
// Notes: Done pulses in the cycle the stop bit is on the pin
`timescale 1ns/100ps
module lreq_serializer #(
  parameter int SH_W = node_phy_pkg::LREQ_SH_W
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic is_write_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] data_i,
  output logic lreq_o,
  output logic busy_o,
  output logic done_o
);

  logic [SH_W-1:0] sh_r;
  logic [4:0] cnt_r;

  assign busy_o = (cnt_r != 5'h00);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_r <= '0;
      cnt_r <= 5'h00;
    end else if (start_i && !busy_o) begin
      if (is_write_i) begin
        sh_r <= {1'b1, node_phy_pkg::LREQ_WR, addr_i, data_i, 1'b0};
        cnt_r <= node_phy_pkg::LREQ_WR_LEN;
      end else begin
        sh_r <= {1'b1, node_phy_pkg::LREQ_RD, addr_i, 1'b0, 8'h00};
        cnt_r <= node_phy_pkg::LREQ_RD_LEN;
      end
    end else if (busy_o) begin
      sh_r <= {sh_r[SH_W-2:0], 1'b0};
      cnt_r <= cnt_r - 5'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lreq_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      lreq_o <= busy_o & sh_r[SH_W-1];
      done_o <= (cnt_r == 5'h01);
    end
  end

endmodule

// file: verilog/node_phy_regs.sv
// Purpose: Node identity and PHY register access registers behind APB
// Assumes: PHY status arrives as one-cycle strobes on the mclk_i domain
// Notes: Interrupt status is write-one-to-clear; a new event beats a clear
//
// Behaviour
// - Node valid clears on bus reset, sets on a new node number.
// - Root flag takes the PHY root report during bus reset.
// - Cable power follows the PHY report; software cannot write it.
// - Node identity bits 29-28 and 26-16 read zero.
// - Bus number bits 15-6 writable, not changed by hardware, reset all ones.
// - Node number bits 5-0 load from PHY after self-id; read-only.
// - Node ID is bus number above node number, sixteen bits.
// - Setting read or write request clears transfer done.
// - Transfer done sets when a PHY register transfer arrives.
// - Returned register address captured in bits 27-24.
// - Returned register data captured in bits 23-16.
// - Read request bit 15 sends a PHY read, then self-clears.
// - Write request bit 14 sends a PHY write, then self-clears.
// - Target address bits 11-8 read/write, reset zero.
// - Write data bits 7-0 read/write, reset zero, used by writes only.
// - PHY access bits 30-28 and 13-12 read zero.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module node_phy_regs #(
  parameter int AW = 12
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire node_phy_pkg::phy_status_t phy_status_i,
  output logic lreq_o,
  output logic [15:0] node_id_o,
  output logic irq_o
);

  logic rst_meta_r;
  logic rst_n;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic node_valid_r;
  logic root_r;
  logic cps_r;
  logic [9:0] bus_number_r;
  logic [5:0] node_number_r;
  logic done_r;
  logic [3:0] raddr_r;
  logic [7:0] rdata_r;
  logic rd_req_r;
  logic wr_req_r;
  logic [3:0] taddr_r;
  logic [7:0] wdata_r;
  logic [2:0] ev_sts_r;
  logic [2:0] ev_msk_r;
  logic irq_r;
  logic [2:0] ev;
  logic wr_acc;
  logic rd_setup;
  logic wr_node;
  logic wr_phy;
  logic req_set;
  logic ser_start;
  logic ser_busy;
  logic ser_done;
  logic st_rst;
  logic st_sid;
  logic st_reg;
  node_phy_pkg::req_state_t state_r;

  function automatic logic is_mapped(input logic [AW-1:0] a);
    return (a == AW'(node_phy_pkg::NODE_ID_OFS)) ||
           (a == AW'(node_phy_pkg::PHY_ACC_OFS)) ||
           (a == AW'(node_phy_pkg::IRQ_STS_OFS)) ||
           (a == AW'(node_phy_pkg::IRQ_MSK_OFS));
  endfunction

  // Reset release through two flops
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  assign st_rst = phy_status_i.valid & phy_status_i.bus_reset;
  assign st_sid = phy_status_i.valid & phy_status_i.self_id_done;
  assign st_reg = phy_status_i.valid & phy_status_i.reg_xfer;
  assign ev = {st_reg, st_sid, st_rst};

  // APB: one wait state, so pready lands on the second access edge
  assign wr_acc = psel_i & penable_i & pwrite_i & pready_r;
  assign rd_setup = psel_i & penable_i & ~pwrite_i & ~pready_r;
  assign wr_node = wr_acc && (paddr_i == AW'(node_phy_pkg::NODE_ID_OFS));
  assign wr_phy = wr_acc && (paddr_i == AW'(node_phy_pkg::PHY_ACC_OFS));
  assign req_set = wr_phy &&
                   (pwdata_i[node_phy_pkg::RDREQ_BIT] |
                    pwdata_i[node_phy_pkg::WRREQ_BIT]);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= psel_i & penable_i & ~pready_r;
      pslverr_r <= psel_i & penable_i & ~pready_r & ~is_mapped(paddr_i);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr_i)
        AW'(node_phy_pkg::NODE_ID_OFS): begin
          prdata_r <= {node_valid_r, root_r, 2'b00, cps_r, 11'h000,
                       bus_number_r, node_number_r};
        end
        AW'(node_phy_pkg::PHY_ACC_OFS): begin
          prdata_r <= {done_r, 3'b000, raddr_r, rdata_r, rd_req_r,
                       wr_req_r, 2'b00, taddr_r, wdata_r};
        end
        AW'(node_phy_pkg::IRQ_STS_OFS): begin
          prdata_r <= {29'h0000_0000, ev_sts_r};
        end
        AW'(node_phy_pkg::IRQ_MSK_OFS): begin
          prdata_r <= {29'h0000_0000, ev_msk_r};
        end
        default: begin
          prdata_r <= 32'h0000_0000;
        end
      endcase
    end else begin
      prdata_r <= 32'h0000_0000;
    end
  end

  // Node identity
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      node_valid_r <= 1'b0;
      root_r <= 1'b0;
    end else begin
      // A reset and a new node number in one strobe leave the node valid
      if (st_sid) begin
        node_valid_r <= 1'b1;
      end else if (st_rst) begin
        node_valid_r <= 1'b0;
      end
      if (st_rst) begin
        root_r <= phy_status_i.root;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cps_r <= 1'b0;
    end else if (phy_status_i.valid) begin
      cps_r <= phy_status_i.cable_power;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_number_r <= node_phy_pkg::BUSNUM_RST;
      node_number_r <= node_phy_pkg::NODENUM_RST;
    end else begin
      if (wr_node) begin
        bus_number_r <= pwdata_i[node_phy_pkg::BUSNUM_LSB +: 10];
      end
      if (st_sid) begin
        node_number_r <= phy_status_i.node_number;
      end
    end
  end

  // Node ID copy; both halves change on the same edge as their fields
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      node_id_o <= {node_phy_pkg::BUSNUM_RST, node_phy_pkg::NODENUM_RST};
    end else begin
      node_id_o <= {wr_node ? pwdata_i[node_phy_pkg::BUSNUM_LSB +: 10] : bus_number_r,
                    st_sid ? phy_status_i.node_number : node_number_r};
    end
  end

  // PHY access: software fields
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      taddr_r <= 4'h0;
      wdata_r <= 8'h00;
    end else if (wr_phy) begin
      taddr_r <= pwdata_i[node_phy_pkg::TADDR_LSB +: 4];
      wdata_r <= pwdata_i[node_phy_pkg::WDATA_LSB +: 8];
    end
  end

  // Request bits: a write of one sets, hardware clears once sent
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_req_r <= 1'b0;
      wr_req_r <= 1'b0;
    end else if (wr_phy && (pwdata_i[node_phy_pkg::RDREQ_BIT] |
                            pwdata_i[node_phy_pkg::WRREQ_BIT])) begin
      rd_req_r <= rd_req_r | pwdata_i[node_phy_pkg::RDREQ_BIT];
      wr_req_r <= wr_req_r | pwdata_i[node_phy_pkg::WRREQ_BIT];
    end else if (ser_done) begin
      rd_req_r <= 1'b0;
      wr_req_r <= 1'b0;
    end
  end

  // Returned transfer; an arriving transfer wins over the clear
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      raddr_r <= 4'h0;
      rdata_r <= 8'h00;
    end else begin
      if (st_reg) begin
        done_r <= 1'b1;
        raddr_r <= phy_status_i.reg_addr;
        rdata_r <= phy_status_i.reg_data;
      end else if (req_set) begin
        done_r <= 1'b0;
      end
    end
  end

  // Request sequencer; read wins if software breaks the one-at-a-time use
  assign ser_start = (state_r == node_phy_pkg::REQ_IDLE) && (rd_req_r | wr_req_r);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= node_phy_pkg::REQ_IDLE;
    end else begin
      case (state_r)
        node_phy_pkg::REQ_IDLE: begin
          if (ser_start) begin
            state_r <= node_phy_pkg::REQ_SEND;
          end
        end
        node_phy_pkg::REQ_SEND: begin
          if (ser_done) begin
            state_r <= node_phy_pkg::REQ_IDLE;
          end
        end
        default: begin
          state_r <= node_phy_pkg::REQ_IDLE;
        end
      endcase
    end
  end

  lreq_serializer #(
    .SH_W(node_phy_pkg::LREQ_SH_W)
  ) u_lreq (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .start_i(ser_start),
    .is_write_i(wr_req_r & ~rd_req_r),
    .addr_i(taddr_r),
    .data_i(wdata_r),
    .lreq_o(lreq_o),
    .busy_o(ser_busy),
    .done_o(ser_done)
  );

  // Interrupts
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ev_sts_r <= 3'h0;
      ev_msk_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      if (wr_acc && (paddr_i == AW'(node_phy_pkg::IRQ_STS_OFS))) begin
        ev_sts_r <= (ev_sts_r & ~pwdata_i[2:0]) | ev;
      end else begin
        ev_sts_r <= ev_sts_r | ev;
      end
      if (wr_acc && (paddr_i == AW'(node_phy_pkg::IRQ_MSK_OFS))) begin
        ev_msk_r <= pwdata_i[2:0];
      end
      irq_r <= |(ev_sts_r & ev_msk_r);
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign irq_o = irq_r;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n);

  a_valid_clear: assert property (st_rst && !st_sid |=> !node_valid_r)
    else $error("node valid not cleared by bus reset");

  a_valid_set: assert property (st_sid |=> node_valid_r &&
    node_number_r == $past(phy_status_i.node_number))
    else $error("node number not loaded after self-id");

  a_root_load: assert property (st_rst |=> root_r == $past(phy_status_i.root))
    else $error("root flag not taken at bus reset");

  a_cps_follow: assert property (phy_status_i.valid |=>
    cps_r == $past(phy_status_i.cable_power))
    else $error("cable power flag does not follow status");

  a_cps_nowrite: assert property (wr_node && !phy_status_i.valid |=> $stable(cps_r))
    else $error("cable power changed by software write");

  a_node_rsvd: assert property (pready_r && $past(paddr_i) == AW'(node_phy_pkg::NODE_ID_OFS)
    |-> prdata_r[29:28] == 2'b00 && prdata_r[26:16] == 11'h000)
    else $error("node identity reserved bits not zero");

  a_phy_rsvd: assert property (pready_r && $past(paddr_i) == AW'(node_phy_pkg::PHY_ACC_OFS)
    |-> prdata_r[30:28] == 3'b000 && prdata_r[13:12] == 2'b00)
    else $error("PHY access reserved bits not zero");

  a_busnum_write: assert property (wr_node |=>
    bus_number_r == $past(pwdata_i[15:6]))
    else $error("bus number write lost");

  a_node_id_cat: assert property (##1 node_id_o == {bus_number_r, node_number_r})
    else $error("node ID is not bus and node number");

  a_done_clear: assert property (req_set && !st_reg |=> !done_r)
    else $error("transfer done not cleared by request");

  a_done_capture: assert property (st_reg |=> done_r &&
    raddr_r == $past(phy_status_i.reg_addr) &&
    rdata_r == $past(phy_status_i.reg_data))
    else $error("returned transfer not captured");

  // Start, type 100 MSB first, then the stop bit four address bits later
  a_req_sent: assert property ($rose(rd_req_r) && state_r == node_phy_pkg::REQ_IDLE
    |-> ##2 lreq_o ##1 lreq_o ##1 !lreq_o ##1 !lreq_o ##5 ser_done ##1 !rd_req_r)
    else $error("read request not sent and cleared");

  a_wr_frame: assert property (ser_start && wr_req_r && !rd_req_r
    |-> ##2 lreq_o ##1 (lreq_o && ser_busy) ##1 !lreq_o ##1 lreq_o ##13 ser_done
    ##1 !wr_req_r)
    else $error("write request frame not completed");

endmodule
